/* File: rotate_unit_map.svh */
// Constants of the one-bit rotate datapath
`ifndef ROTATE_UNIT_MAP_SVH
`define ROTATE_UNIT_MAP_SVH

// Operand width and the two wrap positions
`define ROT_WIDTH     8
`define ROT_MSB       7
`define ROT_LSB       0

// Reset values of the registered outputs
`define ROT_RST_DATA  8'h00
`define ROT_RST_FLAG  1'b0

// Cycles from a taken request to its registered strobes
`define ROT_LATENCY   1

`endif

/* File: rotate_unit_pkg.sv */
// Types shared by the rotate datapath modules
package rotate_unit_pkg;

	// Rotate operation selected by the decoder
	typedef enum logic [1:0] {
		rotate_left_plain,
		rotate_left_thru_carry,
		rotate_left_thru_carry_to_acc,
		rotate_right_plain
	} rot_op_t;

endpackage

/* File: rot_if.sv */
// Carrier between the rotate control and the combinational rotator
`timescale 1ns/1ps

interface rot_if #(
	parameter int WIDTH = 8
);
	rotate_unit_pkg::rot_op_t op;
	logic [WIDTH-1:0]         operand;
	logic                     carry_in;
	logic [WIDTH-1:0]         result;
	logic                     carry_res;
	logic                     to_mem;
	logic                     to_acc;
	logic                     carry_upd;

	// Control side drives the request, reads the result
	modport ctrl (
		output op,
		output operand,
		output carry_in,
		input  result,
		input  carry_res,
		input  to_mem,
		input  to_acc,
		input  carry_upd
	);

	// Rotator side computes from the request
	modport core (
		input  op,
		input  operand,
		input  carry_in,
		output result,
		output carry_res,
		output to_mem,
		output to_acc,
		output carry_upd
	);
endinterface

/* File: rotate_core.sv */
// Combinational one-bit rotator with destination and carry decode
`timescale 1ns/1ps

module rotate_core #(
	parameter int WIDTH = 8
) (
	rot_if.core rif
);

	// Shift left by one, given bit entering at the bottom
	function automatic logic [WIDTH-1:0] rot_left(
		input logic [WIDTH-1:0] v,
		input logic             fill
	);
		rot_left = {v[WIDTH-2:0], fill};
	endfunction

	// Shift right by one, given bit entering at the top
	function automatic logic [WIDTH-1:0] rot_right(
		input logic [WIDTH-1:0] v,
		input logic             fill
	);
		rot_right = {fill, v[WIDTH-1:1]};
	endfunction

	// Result, destination and carry per operation
	always_comb begin
		rif.result    = rif.operand;
		rif.carry_res = rif.carry_in;
		rif.to_mem    = 1'b0;
		rif.to_acc    = 1'b0;
		rif.carry_upd = 1'b0;
		case (rif.op)
			rotate_unit_pkg::rotate_left_plain: begin
				// Bit 7 wraps to bit 0, carry untouched
				rif.result = rot_left(rif.operand, rif.operand[WIDTH-1]);
				rif.to_mem = 1'b1;
			end
			rotate_unit_pkg::rotate_left_thru_carry: begin
				rif.result    = rot_left(rif.operand, rif.carry_in);
				rif.carry_res = rif.operand[WIDTH-1];
				rif.carry_upd = 1'b1;
				rif.to_mem    = 1'b1;
			end
			rotate_unit_pkg::rotate_left_thru_carry_to_acc: begin
				// Same rotation, memory left alone
				rif.result    = rot_left(rif.operand, rif.carry_in);
				rif.carry_res = rif.operand[WIDTH-1];
				rif.carry_upd = 1'b1;
				rif.to_acc    = 1'b1;
			end
			rotate_unit_pkg::rotate_right_plain: begin
				// Bit 0 wraps to bit 7, no carry involved
				rif.result = rot_right(rif.operand, rif.operand[0]);
				rif.to_mem = 1'b1;
			end
			default: begin
				rif.result = rif.operand;
			end
		endcase
	end

endmodule

/* File: rotate_unit.sv */
// Rotate datapath top: registers rotator results toward memory, acc, carry
`timescale 1ns/1ps
`include "rotate_unit_map.svh"

module rotate_unit #(
	parameter int WIDTH = `ROT_WIDTH
) (
	input  wire logic                     core_clk,
	input  wire logic                     resetn,
	input  wire logic                     op_valid,
	input  wire rotate_unit_pkg::rot_op_t op_sel,
	input  wire logic [WIDTH-1:0]         operand,
	input  wire logic                     carry_in,
	output logic [WIDTH-1:0]              mem_wdata,
	output logic                          mem_we,
	output logic [WIDTH-1:0]              acc_wdata,
	output logic                          acc_we,
	output logic                          carry_out,
	output logic                          carry_we,
	output logic                          done
);

	logic [WIDTH-1:0] next_mem_wdata;
	logic             next_mem_we;
	logic [WIDTH-1:0] next_acc_wdata;
	logic             next_acc_we;
	logic             next_carry_out;
	logic             next_carry_we;
	logic             next_done;

	rot_if #(.WIDTH(WIDTH)) rif ();

	// Request straight into the rotator; it has no state
	assign rif.op       = op_sel;
	assign rif.operand  = operand;
	assign rif.carry_in = carry_in;

	rotate_core #(
		.WIDTH(WIDTH)
	) u_core (
		.rif(rif.core)
	);

	// Steer the rotated value; data buses hold last value when idle.
	// carry_out only holds the last result: back-to-back carry rotates rely on the
	// core feeding the updated flag back on carry_in; no forwarding path is built.
	always_comb begin
		next_mem_wdata = mem_wdata;
		next_acc_wdata = acc_wdata;
		next_carry_out = carry_out;
		next_mem_we    = 1'b0;
		next_acc_we    = 1'b0;
		next_carry_we  = 1'b0;
		next_done      = 1'b0;
		if (op_valid) begin
			next_done = 1'b1;
			if (rif.to_mem) begin
				next_mem_wdata = rif.result;
				next_mem_we    = 1'b1;
			end
			if (rif.to_acc) begin
				// No memory strobe here, operand stays as it was
				next_acc_wdata = rif.result;
				next_acc_we    = 1'b1;
			end
			if (rif.carry_upd) begin
				// Plain rotates never raise this strobe
				next_carry_out = rif.carry_res;
				next_carry_we  = 1'b1;
			end
		end
	end

	// Outputs registered so the core sees clean strobes
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			mem_wdata <= WIDTH'(`ROT_RST_DATA);
			mem_we    <= `ROT_RST_FLAG;
			acc_wdata <= WIDTH'(`ROT_RST_DATA);
			acc_we    <= `ROT_RST_FLAG;
			carry_out <= `ROT_RST_FLAG;
			carry_we  <= `ROT_RST_FLAG;
			done      <= `ROT_RST_FLAG;
		end else begin
			mem_wdata <= next_mem_wdata;
			mem_we    <= next_mem_we;
			acc_wdata <= next_acc_wdata;
			acc_we    <= next_acc_we;
			carry_out <= next_carry_out;
			carry_we  <= next_carry_we;
			done      <= next_done;
		end
	end

	// Checks on the registered results, one cycle after the request
	carry_rot_mem_a: assert property (
		@(posedge core_clk) disable iff (!resetn)
		op_valid && op_sel == rotate_unit_pkg::rotate_left_thru_carry
		|=> mem_we && carry_we && !acc_we
		&& mem_wdata == {$past(operand[WIDTH-2:0]), $past(carry_in)}
		&& carry_out == $past(operand[WIDTH-1])
	) else $error("carry left rotate to memory wrong");

	acc_dest_a: assert property (
		@(posedge core_clk) disable iff (!resetn)
		op_valid && op_sel == rotate_unit_pkg::rotate_left_thru_carry_to_acc
		|=> acc_we && !mem_we && $stable(mem_wdata)
	) else $error("acc form touched memory or missed acc");

	acc_bits_a: assert property (
		@(posedge core_clk) disable iff (!resetn)
		op_valid && op_sel == rotate_unit_pkg::rotate_left_thru_carry_to_acc
		|=> carry_we && carry_out == $past(operand[WIDTH-1])
		&& acc_wdata[0] == $past(carry_in)
		&& acc_wdata[WIDTH-1:1] == $past(operand[WIDTH-2:0])
	) else $error("acc form bits or carry wrong");

	right_carry_a: assert property (
		@(posedge core_clk) disable iff (!resetn)
		op_valid && op_sel == rotate_unit_pkg::rotate_right_plain
		|=> !carry_we && $stable(carry_out)
		&& mem_wdata[WIDTH-1] == $past(operand[0])
	) else $error("right rotate touched carry or bad wrap");

	right_bits_a: assert property (
		@(posedge core_clk) disable iff (!resetn)
		op_valid && op_sel == rotate_unit_pkg::rotate_right_plain
		|=> mem_we && !acc_we
		&& mem_wdata[WIDTH-2:0] == $past(operand[WIDTH-1:1])
	) else $error("right rotate bits wrong");

	left_plain_a: assert property (
		@(posedge core_clk) disable iff (!resetn)
		op_valid && op_sel == rotate_unit_pkg::rotate_left_plain
		|=> mem_we && !carry_we && !acc_we
		&& mem_wdata == {$past(operand[WIDTH-2:0]), $past(operand[WIDTH-1])}
	) else $error("plain left rotate wrong");

	idle_quiet_a: assert property (
		@(posedge core_clk) disable iff (!resetn)
		!op_valid |=> !mem_we && !acc_we && !carry_we && !done
	) else $error("strobe without request");

	// Hold checks for idle and the three memory-form operations, exclusivity checks across all requests

	done_strobe_a: assert property (
		@(posedge core_clk) disable iff (!resetn)
		op_valid |=> done
	) else $error("request taken without done");

	// Held data lets the core read results late without its own latch
	idle_hold_a: assert property (
		@(posedge core_clk) disable iff (!resetn)
		!op_valid |=> $stable(mem_wdata) && $stable(acc_wdata)
		&& $stable(carry_out)
	) else $error("held output moved while idle");

	// Plain left rotate leaves flag and accumulator as they were
	left_carry_a: assert property (
		@(posedge core_clk) disable iff (!resetn)
		op_valid && op_sel == rotate_unit_pkg::rotate_left_plain
		|=> $stable(carry_out) && $stable(acc_wdata)
	) else $error("plain left rotate touched carry or acc");

	// Right rotate goes back to memory only
	right_acc_a: assert property (
		@(posedge core_clk) disable iff (!resetn)
		op_valid && op_sel == rotate_unit_pkg::rotate_right_plain
		|=> $stable(acc_wdata)
	) else $error("right rotate touched acc data");

	// Memory form of the carry rotate leaves the accumulator alone
	carry_acc_a: assert property (
		@(posedge core_clk) disable iff (!resetn)
		op_valid && op_sel == rotate_unit_pkg::rotate_left_thru_carry
		|=> $stable(acc_wdata) && !acc_we
	) else $error("carry rotate to memory touched acc");

	// Memory and accumulator are never both written by one request
	one_dest_a: assert property (
		@(posedge core_clk) disable iff (!resetn)
		!(mem_we && acc_we)
	) else $error("memory and acc written together");

	strobe_done_a: assert property (
		@(posedge core_clk) disable iff (!resetn)
		mem_we || acc_we || carry_we |-> done
	) else $error("write strobe without done");

	// Carry strobe only comes with a data strobe, never alone
	carry_pair_a: assert property (
		@(posedge core_clk) disable iff (!resetn)
		carry_we |-> mem_we || acc_we
	) else $error("carry strobe without a data strobe");

	// Main scenarios
	carry_rot_c: cover property (
		@(posedge core_clk) disable iff (!resetn)
		op_valid && op_sel == rotate_unit_pkg::rotate_left_thru_carry
		&& carry_in && operand[WIDTH-1]
	);

	acc_rot_c: cover property (
		@(posedge core_clk) disable iff (!resetn)
		op_valid && op_sel == rotate_unit_pkg::rotate_left_thru_carry_to_acc
	);

	right_rot_c: cover property (
		@(posedge core_clk) disable iff (!resetn)
		op_valid && op_sel == rotate_unit_pkg::rotate_right_plain
		&& operand[0]
	);

	back_to_back_c: cover property (
		@(posedge core_clk) disable iff (!resetn)
		op_valid ##1 op_valid
	);

	left_rot_c: cover property (
		@(posedge core_clk) disable iff (!resetn)
		op_valid && op_sel == rotate_unit_pkg::rotate_left_plain
		&& operand[WIDTH-1]
	);

endmodule

/* File: rotate_store_model.sv */
// Data memory byte, accumulator and carry flag loaded by the strobes
`timescale 1ns/1ps

module rotate_store_model (
	input  wire logic       core_clk,
	input  wire logic       resetn,
	input  wire logic       mem_we,
	input  wire logic [7:0] mem_wdata,
	input  wire logic       acc_we,
	input  wire logic [7:0] acc_wdata,
	input  wire logic       carry_we,
	input  wire logic       carry_out,
	output logic [7:0]      mem_q,
	output logic [7:0]      acc_q,
	output logic            carry_q
);
	// Each store loads only under its own strobe, as the core would
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			mem_q <= 8'h00;
			acc_q <= 8'h00;
			carry_q <= 1'b0;
		end else begin
			if (mem_we) mem_q <= mem_wdata;
			if (acc_we) acc_q <= acc_wdata;
			if (carry_we) carry_q <= carry_out;
		end
	end
endmodule

/* File: rotate_unit_test.sv */
// Self-checking bench of the rotate datapath
`timescale 1ns/1ps

module rotate_unit_test;
	logic                     core_clk, resetn, op_valid, carry_in;
	rotate_unit_pkg::rot_op_t op_sel;
	logic [7:0]               operand, mem_wdata, acc_wdata, mem_q, last_mem;
	logic [7:0]               acc_q, last_acc;
	logic                     mem_we, acc_we, carry_out, carry_we, done;
	logic                     carry_q, last_carry;
	logic [31:0]              seed;
	int                       err_count, checks_done;
	logic                     pv, pc;
	rotate_unit_pkg::rot_op_t po;
	logic [7:0]               pd;
	logic [8:0]               e;

	rotate_unit i_rotate_unit (.core_clk(core_clk), .resetn(resetn),
		.op_valid(op_valid), .op_sel(op_sel), .operand(operand),
		.carry_in(carry_in), .mem_wdata(mem_wdata), .mem_we(mem_we),
		.acc_wdata(acc_wdata), .acc_we(acc_we), .carry_out(carry_out),
		.carry_we(carry_we), .done(done));
	rotate_store_model i_rotate_store_model (.core_clk(core_clk),
		.resetn(resetn), .mem_we(mem_we), .mem_wdata(mem_wdata),
		.acc_we(acc_we), .acc_wdata(acc_wdata), .carry_we(carry_we),
		.carry_out(carry_out), .mem_q(mem_q), .acc_q(acc_q),
		.carry_q(carry_q));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Returns {new carry, rotated byte}; plain forms pass carry through
	function automatic logic [8:0] rot(input logic [1:0] o,
		input logic [7:0] d, input logic c);
		case (o)
			2'h0: rot = {c, d[6:0], d[7]};
			2'h3: rot = {c, d[0], d[7:1]};
			default: rot = {d[7], d[6:0], c};
		endcase
	endfunction

	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic req(input logic v, input logic [1:0] o,
		input logic [7:0] d, input logic c);
		@(posedge core_clk);
		op_valid <= v;
		op_sel <= rotate_unit_pkg::rot_op_t'(o);
		operand <= d;
		carry_in <= c;
	endtask

	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	// Request sampled at the edge that takes it, its outputs just after
	always @(posedge core_clk) begin
		pv = op_valid & resetn;
		po = op_sel;
		pd = operand;
		pc = carry_in;
		#1;
		e = rot(po, pd, pc);
		if (resetn && pv) begin
			if (po == 2'h0) check({1'b0, mem_wdata}, {1'b0, e[7:0]});
			if (po == 2'h1) check({carry_out, mem_wdata}, e);
			if (po == 2'h2) check({carry_out, acc_wdata}, e);
			if (po == 2'h3) check({1'b0, mem_wdata}, {1'b0, e[7:0]});
			if (po != 2'h2) last_mem = e[7:0];
			if (po == 2'h2) last_acc = e[7:0];
			if (po == 2'h1 || po == 2'h2) last_carry = e[8];
		end
		if (resetn) begin
			check({acc_we, mem_we}, {pv && po == 2'h2, pv && po != 2'h2});
			check(carry_we, pv && (po == 2'h1 || po == 2'h2));
			check(done, pv);
		end
	end

	initial begin
		#(40 * 3000);
		err_count++;
		results();
	end

	initial begin
		{resetn, op_valid, carry_in, pv} = 4'h0;
		op_sel = rotate_unit_pkg::rotate_left_plain;
		operand = 8'h00;
		seed = 32'h188c;
		last_mem = 8'h00;
		last_acc = 8'h00;
		last_carry = 1'b0;
		err_count = 0;
		checks_done = 0;
		repeat (10) @(posedge core_clk);
		#1 check({mem_we, acc_we, carry_we, done, carry_out, 4'h0}, 9'h0);
		repeat (10) @(posedge core_clk);
		resetn <= 1'b1;
		// Walk values, all-ones with carry clear and all-zeros with carry set, every op
		for (int o = 0; o < 4; o++) begin
			req(1'b1, o[1:0], 8'h81, 1'b0);
			req(1'b1, o[1:0], 8'hff, 1'b0);
			req(1'b1, o[1:0], 8'h00, 1'b1);
			req(1'b1, o[1:0], 8'h01, 1'b1);
		end
		req(1'b0, 2'h0, 8'h00, 1'b0);
		$display("corner test done");
		// Mid-run reset: done, acc_we, held data and the memory store checked clear
		@(posedge core_clk);
		resetn <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1 check({mem_wdata, done}, 9'h0);
		check({acc_wdata, acc_we}, 9'h0);
		check({mem_q, carry_out}, 9'h0);
		{last_mem, last_acc, last_carry} = 17'h0;
		@(posedge core_clk);
		resetn <= 1'b1;
		$display("reset test done");
		// Random mix, back to back with idle gaps
		for (int i = 0; i < 500; i++) begin
			seed = lfsr(seed);
			req(seed[12] | seed[5], seed[1:0], seed[20:13], seed[8]);
		end
		req(1'b0, 2'h0, 8'h00, 1'b0);
		repeat (2) @(posedge core_clk);
		#2 check({1'b0, mem_q}, {1'b0, last_mem});
		check({carry_q, acc_q}, {last_carry, last_acc});
		$display("random test done");
		results();
	end
endmodule
